// file: hdl/frs_pkg.sv
`default_nettype none
package frs_pkg;
  // handshake words
  localparam logic [31:0] CODE_ENABLED  = 32'h8888_8888;
  localparam logic [31:0] CODE_START    = 32'h0000_1234;
  localparam logic [31:0] CODE_READY    = 32'h0000_5678;
  localparam logic [31:0] CODE_ERASE_OK = 32'h0000_9999;
  localparam logic [31:0] CODE_WR_REQ   = 32'h1111_1111;
  localparam logic [31:0] CODE_WR_END   = 32'ha5a5_5a5a;
  localparam logic [31:0] IDLE_WORD     = 32'hffff_ffff;
  localparam logic [31:0] PE_OFFSET     = 32'h8080_0000;
  localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;
  localparam logic [3:0]  RX_PRIORITY   = 4'ha;
  // link timing
  localparam int CLK_HZ      = 20_000_000;
  localparam int BIT_RATE_HZ = 1_000_000;
  localparam int HALF_CYC    = CLK_HZ / (2 * BIT_RATE_HZ);
  localparam int DELAY_CYC   = CLK_HZ / BIT_RATE_HZ;
  localparam logic [4:0] HALF_LAST = 5'(HALF_CYC - 1);
  localparam logic [4:0] DLY_LAST  = 5'(DELAY_CYC - 1);
  localparam int WORD_BITS  = 32;
  localparam logic [4:0] BIT_LAST  = 5'(WORD_BITS - 1);
  localparam logic [2:0] FRM_ONE   = 3'h1;
  localparam logic [2:0] FRM_BURST = 3'h4;
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_WORDS = PAGE_BYTES / 4;
  localparam logic [5:0] PAGE_LAST = 6'(PAGE_WORDS - 1);
  // register map, byte addresses
  localparam logic [4:0] REG_CTRL  = 5'h00;
  localparam logic [4:0] REG_STAT  = 5'h04;
  localparam logic [4:0] REG_ERASE = 5'h08;
  localparam logic [4:0] REG_WADDR = 5'h0c;
  localparam logic [4:0] REG_WNUM  = 5'h10;
  localparam logic [4:0] REG_DLCNT = 5'h14;
  localparam int CTRL_GO     = 0;
  localparam int STAT_FLAG   = 0;
  localparam int STAT_LD1    = 1;
  localparam int STAT_LD2    = 2;
  localparam int STAT_DONE   = 3;
  localparam int STAT_PRIO   = 4;
  localparam int STAT_STATE  = 8;
  typedef enum logic [16:0] {
    M_IDLE   = 17'h00001,
    M_EN     = 17'h00002,
    M_WSTART = 17'h00004,
    M_READY  = 17'h00008,
    M_WERASE = 17'h00010,
    M_EACK   = 17'h00020,
    M_ERASE  = 17'h00040,
    M_EEND   = 17'h00080,
    M_WADDR  = 17'h00100,
    M_AACK   = 17'h00200,
    M_WCNT   = 17'h00400,
    M_CACK   = 17'h00800,
    M_REQ    = 17'h01000,
    M_DATA   = 17'h02000,
    M_SWAP   = 17'h04000,
    M_DRAIN  = 17'h08000,
    M_WEND   = 17'h10000
  } frs_main_type;
  localparam frs_main_type M_DONE_ALIAS = M_IDLE;
  typedef enum logic [5:0] {
    SP_IDLE = 6'h01,
    SP_LEAD = 6'h02,
    SP_LOW  = 6'h04,
    SP_HIGH = 6'h08,
    SP_LAG  = 6'h10,
    SP_GAP  = 6'h20
  } frs_spi_type;
endpackage
`default_nettype wire

// file: hdl/frs_reload_master.sv
// Summary of operation
// - send enabled code once started
// - wait for start code before proceeding
// - send ready code after start
// - echo erase word before erasing
// - send erase-complete code after all blocks
// - store and echo write start address
// - store and echo write count
// - send data request code per page
// - 32-bit MSB-first words; bursts of four
// - flag picks programming and filling buffer
// - per-buffer loaded flag gates programming
// - word index advances per received word
// - receive-complete event writes filling buffer
// - erase and program only host ranges
// - signal resume from flash when done
// - program flash address is write address plus offset; erase address is block number
`timescale 1ns/10ps
`default_nettype none
module frs_reload_master (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        clkEn,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             serial_clock_line,
  output logic             mosi,
  input  wire logic        miso,
  output logic             slave_select_line,
  output logic             flashReq,
  output logic             flashErase,
  output logic      [31:0] flashAddr,
  output logic      [31:0] flashData,
  input  wire logic        flashAck,
  output logic             resumeFromFlash
);
  typedef struct packed {
    frs_pkg::frs_main_type st;
    frs_pkg::frs_spi_type  sp;
    logic [4:0]  spCnt;
    logic [4:0]  spBit;
    logic [2:0]  spFrm;
    logic        sclk;
    logic        mosi;
    logic        ssl;
    logic [31:0] txSh;
    logic [31:0] txWord;
    logic [31:0] rxSh;
    logic        frmEv;
    logic        burstEv;
    logic        lau;
    logic        misoMeta;
    logic        misoSync;
    logic [1:0][frs_pkg::PAGE_WORDS-1:0][31:0] wbuf;
    logic [1:0]  loaded;
    logic        status;
    logic [5:0]  fillIdx;
    logic [5:0]  progIdx;
    logic [31:0] eraseWord;
    logic [7:0]  eraseK;
    logic [31:0] wrAddr;
    logic [31:0] wrNum;
    logic [31:0] dlCnt;
    logic [31:0] progAddr;
    logic        fReq;
    logic        fErase;
    logic [31:0] fAddr;
    logic [31:0] fData;
    logic        waitReq;
    logic [31:0] rdData;
    logic        done;
  } frs_state_type;

  frs_state_type s_ff;
  frs_state_type nxt_s;

  function automatic logic regHit(input logic [4:0] a,
                                  input logic [4:0] off);
    return a == off;
  endfunction

  logic        launch;
  logic [31:0] lWord;
  logic [2:0]  lFrm;
  logic        fillSel;
  logic        progSel;

  always_comb begin
    nxt_s = s_ff;
    launch = 1'b0;
    lWord = frs_pkg::IDLE_WORD;
    lFrm = frs_pkg::FRM_ONE;
    fillSel = s_ff.status;
    progSel = !s_ff.status;
    nxt_s.frmEv = 1'b0;
    nxt_s.burstEv = 1'b0;
    nxt_s.misoMeta = miso;
    nxt_s.misoSync = s_ff.misoMeta;
    // serial engine, clock idles high, sample at end of high half
    unique case (s_ff.sp)
      frs_pkg::SP_IDLE: ;
      frs_pkg::SP_LEAD: begin
        if (s_ff.spCnt == frs_pkg::DLY_LAST) begin
          nxt_s.spCnt = '0;
          nxt_s.sp = frs_pkg::SP_LOW;
          nxt_s.sclk = 1'b0;
          nxt_s.mosi = s_ff.txSh[31];
        end else begin
          nxt_s.spCnt = s_ff.spCnt + 5'h1;
        end
      end
      frs_pkg::SP_LOW: begin
        if (s_ff.spCnt == frs_pkg::HALF_LAST) begin
          nxt_s.spCnt = '0;
          nxt_s.sp = frs_pkg::SP_HIGH;
          nxt_s.sclk = 1'b1;
        end else begin
          nxt_s.spCnt = s_ff.spCnt + 5'h1;
        end
      end
      frs_pkg::SP_HIGH: begin
        if (s_ff.spCnt == frs_pkg::HALF_LAST) begin
          // late sampling absorbs the two-stage input sync
          nxt_s.spCnt = '0;
          nxt_s.rxSh = {s_ff.rxSh[30:0], s_ff.misoSync};
          if (s_ff.spBit == frs_pkg::BIT_LAST) begin
            nxt_s.frmEv = 1'b1;
            nxt_s.spBit = '0;
            nxt_s.txSh = s_ff.txWord;
            if (s_ff.spFrm == frs_pkg::FRM_ONE) begin
              nxt_s.sp = frs_pkg::SP_LAG;
            end else begin
              nxt_s.spFrm = s_ff.spFrm - 3'h1;
              nxt_s.sp = frs_pkg::SP_LOW;
              nxt_s.sclk = 1'b0;
              nxt_s.mosi = s_ff.txWord[31];
            end
          end else begin
            nxt_s.spBit = s_ff.spBit + 5'h1;
            nxt_s.txSh = {s_ff.txSh[30:0], 1'b1};
            nxt_s.sp = frs_pkg::SP_LOW;
            nxt_s.sclk = 1'b0;
            nxt_s.mosi = s_ff.txSh[30];
          end
        end else begin
          nxt_s.spCnt = s_ff.spCnt + 5'h1;
        end
      end
      frs_pkg::SP_LAG: begin
        if (s_ff.spCnt == frs_pkg::DLY_LAST) begin
          nxt_s.spCnt = '0;
          nxt_s.ssl = 1'b0;
          nxt_s.mosi = 1'b1;
          nxt_s.sp = frs_pkg::SP_GAP;
        end else begin
          nxt_s.spCnt = s_ff.spCnt + 5'h1;
        end
      end
      frs_pkg::SP_GAP: begin
        if (s_ff.spCnt == frs_pkg::DLY_LAST) begin
          nxt_s.spCnt = '0;
          nxt_s.sp = frs_pkg::SP_IDLE;
          nxt_s.burstEv = 1'b1;
        end else begin
          nxt_s.spCnt = s_ff.spCnt + 5'h1;
        end
      end
      default: nxt_s.sp = frs_pkg::SP_IDLE;
    endcase

    // handshake sequencer; polls send idle words
    unique case (s_ff.st)
      frs_pkg::M_IDLE: ;
      frs_pkg::M_EN: begin
        launch = !s_ff.lau;
        lWord = frs_pkg::CODE_ENABLED;
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          nxt_s.st = frs_pkg::M_WSTART;
        end
      end
      frs_pkg::M_WSTART: begin
        launch = !s_ff.lau;
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          if (s_ff.rxSh == frs_pkg::CODE_START) begin
            nxt_s.st = frs_pkg::M_READY;
          end
        end
      end
      frs_pkg::M_READY: begin
        // no flash code is run from here, so ready follows start
        launch = !s_ff.lau;
        lWord = frs_pkg::CODE_READY;
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          nxt_s.st = frs_pkg::M_WERASE;
        end
      end
      frs_pkg::M_WERASE: begin
        launch = !s_ff.lau;
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          if (s_ff.rxSh != frs_pkg::IDLE_WORD) begin
            nxt_s.eraseWord = s_ff.rxSh;
            nxt_s.st = frs_pkg::M_EACK;
          end
        end
      end
      frs_pkg::M_EACK: begin
        launch = !s_ff.lau;
        lWord = s_ff.eraseWord;
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          nxt_s.eraseK = '0;
          nxt_s.st = frs_pkg::M_ERASE;
        end
      end
      frs_pkg::M_ERASE: begin
        if (s_ff.fReq && flashAck) begin
          nxt_s.fReq = 1'b0;
          nxt_s.eraseK = s_ff.eraseK + 8'h1;
        end else if (!s_ff.fReq) begin
          if (s_ff.eraseK != s_ff.eraseWord[7:0]) begin
            nxt_s.fReq = 1'b1;
            nxt_s.fErase = 1'b1;
            nxt_s.fAddr = {24'h0, 8'(s_ff.eraseWord[15:8] + s_ff.eraseK)};
          end else begin
            nxt_s.st = frs_pkg::M_EEND;
          end
        end
      end
      frs_pkg::M_EEND: begin
        launch = !s_ff.lau;
        lWord = frs_pkg::CODE_ERASE_OK;
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          nxt_s.st = frs_pkg::M_WADDR;
        end
      end
      frs_pkg::M_WADDR: begin
        launch = !s_ff.lau;
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          if (s_ff.rxSh != frs_pkg::IDLE_WORD) begin
            nxt_s.wrAddr = s_ff.rxSh;
            nxt_s.progAddr = s_ff.rxSh + frs_pkg::PE_OFFSET;
            nxt_s.st = frs_pkg::M_AACK;
          end
        end
      end
      frs_pkg::M_AACK: begin
        launch = !s_ff.lau;
        lWord = s_ff.wrAddr;
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          nxt_s.st = frs_pkg::M_WCNT;
        end
      end
      frs_pkg::M_WCNT: begin
        launch = !s_ff.lau;
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          if (s_ff.rxSh != frs_pkg::IDLE_WORD) begin
            nxt_s.wrNum = s_ff.rxSh;
            nxt_s.st = frs_pkg::M_CACK;
          end
        end
      end
      frs_pkg::M_CACK: begin
        launch = !s_ff.lau;
        lWord = s_ff.wrNum;
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          nxt_s.st = (s_ff.wrNum == '0) ? frs_pkg::M_WEND
                                        : frs_pkg::M_REQ;
        end
      end
      frs_pkg::M_REQ: begin
        launch = !s_ff.lau;
        lWord = frs_pkg::CODE_WR_REQ;
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          nxt_s.st = frs_pkg::M_DATA;
        end
      end
      frs_pkg::M_DATA: begin
        launch = !s_ff.lau;
        lFrm = frs_pkg::FRM_BURST;
        if (s_ff.frmEv) begin
          nxt_s.wbuf[fillSel][s_ff.fillIdx] = s_ff.rxSh;
          nxt_s.fillIdx = s_ff.fillIdx + 6'h1;
        end
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          if (s_ff.fillIdx == '0) begin
            nxt_s.loaded[fillSel] = 1'b1;
            nxt_s.dlCnt = s_ff.dlCnt + 32'h1;
            nxt_s.st = frs_pkg::M_SWAP;
          end
        end
      end
      frs_pkg::M_SWAP: begin
        if (!s_ff.loaded[progSel] && !s_ff.fReq) begin
          nxt_s.status = !s_ff.status;
          nxt_s.st = (s_ff.dlCnt == s_ff.wrNum) ? frs_pkg::M_DRAIN
                                                : frs_pkg::M_REQ;
        end
      end
      frs_pkg::M_DRAIN: begin
        if (s_ff.loaded == '0 && !s_ff.fReq) begin
          nxt_s.st = frs_pkg::M_WEND;
        end
      end
      frs_pkg::M_WEND: begin
        launch = !s_ff.lau;
        lWord = frs_pkg::CODE_WR_END;
        if (s_ff.burstEv) begin
          nxt_s.lau = 1'b0;
          nxt_s.done = 1'b1;
          nxt_s.st = frs_pkg::M_IDLE;
        end
      end
      default: nxt_s.st = frs_pkg::M_IDLE;
    endcase

    if (launch) begin
      nxt_s.lau = 1'b1;
      nxt_s.sp = frs_pkg::SP_LEAD;
      nxt_s.ssl = 1'b1;
      nxt_s.spCnt = '0;
      nxt_s.spBit = '0;
      nxt_s.spFrm = lFrm;
      nxt_s.txWord = lWord;
      nxt_s.txSh = lWord;
    end

    // programmer drains the loaded buffer while the other fills
    if (s_ff.st != frs_pkg::M_ERASE) begin
      if (s_ff.fReq && flashAck) begin
        nxt_s.fReq = 1'b0;
        nxt_s.progIdx = s_ff.progIdx + 6'h1;
        nxt_s.progAddr = s_ff.progAddr + frs_pkg::WORD_BYTES;
        if (s_ff.progIdx == frs_pkg::PAGE_LAST) begin
          nxt_s.loaded[progSel] = 1'b0;
        end
      end else if (!s_ff.fReq && s_ff.loaded[progSel]) begin
        nxt_s.fReq = 1'b1;
        nxt_s.fErase = 1'b0;
        nxt_s.fAddr = s_ff.progAddr;
        nxt_s.fData = s_ff.wbuf[progSel][s_ff.progIdx];
      end
    end

    // bus slave: one wait cycle, then answer
    nxt_s.waitReq = !((read || write) && s_ff.waitReq);
    if (read && s_ff.waitReq) begin
      nxt_s.rdData = '0;
      if (regHit(address, frs_pkg::REG_CTRL)) begin
        nxt_s.rdData[frs_pkg::CTRL_GO] = s_ff.st != frs_pkg::M_IDLE;
      end else if (regHit(address, frs_pkg::REG_STAT)) begin
        nxt_s.rdData[frs_pkg::STAT_FLAG] = s_ff.status;
        nxt_s.rdData[frs_pkg::STAT_LD1] = s_ff.loaded[0];
        nxt_s.rdData[frs_pkg::STAT_LD2] = s_ff.loaded[1];
        nxt_s.rdData[frs_pkg::STAT_DONE] = s_ff.done;
        nxt_s.rdData[frs_pkg::STAT_PRIO +: 4] = frs_pkg::RX_PRIORITY;
        nxt_s.rdData[frs_pkg::STAT_STATE +: 17] = s_ff.st;
      end else if (regHit(address, frs_pkg::REG_ERASE)) begin
        nxt_s.rdData = s_ff.eraseWord;
      end else if (regHit(address, frs_pkg::REG_WADDR)) begin
        nxt_s.rdData = s_ff.wrAddr;
      end else if (regHit(address, frs_pkg::REG_WNUM)) begin
        nxt_s.rdData = s_ff.wrNum;
      end else if (regHit(address, frs_pkg::REG_DLCNT)) begin
        nxt_s.rdData = s_ff.dlCnt;
      end
    end
    if (write && !s_ff.waitReq && regHit(address, frs_pkg::REG_CTRL)
        && writedata[frs_pkg::CTRL_GO] && s_ff.st == frs_pkg::M_IDLE) begin
      nxt_s.st = frs_pkg::M_EN;
      nxt_s.status = 1'b0;
      nxt_s.loaded = '0;
      nxt_s.fillIdx = '0;
      nxt_s.progIdx = '0;
      nxt_s.dlCnt = '0;
      nxt_s.done = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '0;
      s_ff.st <= frs_pkg::M_IDLE;
      s_ff.sp <= frs_pkg::SP_IDLE;
      s_ff.sclk <= 1'b1;
      s_ff.mosi <= 1'b1;
      s_ff.waitReq <= 1'b1;
    end else if (clkEn) begin
      s_ff <= nxt_s;
    end
  end

  assign readdata = s_ff.rdData;
  assign waitrequest = s_ff.waitReq;
  assign serial_clock_line = s_ff.sclk;
  assign mosi = s_ff.mosi;
  assign slave_select_line = s_ff.ssl;
  assign flashReq = s_ff.fReq;
  assign flashErase = s_ff.fErase;
  assign flashAddr = s_ff.fAddr;
  assign flashData = s_ff.fData;
  assign resumeFromFlash = s_ff.done;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n || !clkEn);

  a_select_lead: assert property ($rose(slave_select_line) |->
    ##19 serial_clock_line ##1 !serial_clock_line)
    else $error("clock delay after select wrong");
  a_half_bit: assert property ($fell(serial_clock_line) |->
    ##9 !serial_clock_line ##1 serial_clock_line)
    else $error("low half period wrong");
  a_enable_word: assert property (($rose(slave_select_line)
    && $past(s_ff.st) == frs_pkg::M_EN) |->
    s_ff.txWord == frs_pkg::CODE_ENABLED)
    else $error("enabled code not sent");
  a_start_gate: assert property ((s_ff.st == frs_pkg::M_WSTART
    && s_ff.burstEv && s_ff.rxSh != frs_pkg::CODE_START) |=>
    s_ff.st == frs_pkg::M_WSTART)
    else $error("left start wait without start code");
  a_erase_echo: assert property (($rose(slave_select_line)
    && s_ff.st == frs_pkg::M_EACK) |->
    s_ff.txWord == s_ff.eraseWord)
    else $error("erase echo differs");
  a_prog_source: assert property ((flashReq && !flashErase) |->
    s_ff.loaded[!s_ff.status]
    && flashData == s_ff.wbuf[!s_ff.status][s_ff.progIdx])
    else $error("programming from wrong buffer");
  a_fill_index: assert property ((s_ff.frmEv && s_ff.st == frs_pkg::M_DATA)
    |=> s_ff.fillIdx == 6'($past(s_ff.fillIdx) + 6'h1))
    else $error("word index not advanced");
  a_erase_range: assert property (($rose(flashReq) && flashErase) |->
    s_ff.eraseK < s_ff.eraseWord[7:0])
    else $error("erase beyond requested count");
  a_resume_after: assert property ($rose(resumeFromFlash) |->
    $past(s_ff.st) == frs_pkg::M_WEND)
    else $error("resume without write end");
  a_bus_answer: assert property (((read || write) && waitrequest) |=>
    !waitrequest)
    else $error("bus answer late");
endmodule
`default_nettype wire

// file: tb/frs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module frs_host_model (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        serial_clock_line,
  input  wire logic        mosi,
  input  wire logic        slave_select_line,
  input  wire logic [31:0] txWord,
  output logic             miso,
  output logic             frameDone,
  output logic      [31:0] rxWord,
  output int               timeErr
);
  logic        sclkQ;
  logic        started;
  logic [31:0] shTx;
  logic [31:0] shRx;
  logic [5:0]  nBit;
  int          lead;
  int          hCnt;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sclkQ <= 1'b1;
      started <= 1'b0;
      shTx <= '1;
      shRx <= '0;
      nBit <= '0;
      lead <= 0;
      hCnt <= 0;
      miso <= 1'b1;
      frameDone <= 1'b0;
      rxWord <= '1;
      timeErr <= 0;
    end else begin
      sclkQ <= serial_clock_line;
      frameDone <= 1'b0;
      hCnt <= hCnt + 1;
      if (!slave_select_line) begin
        // not selected: toggle so a stale bit never looks valid
        miso <= ~miso;
        started <= 1'b0;
        lead <= 0;
      end else begin
        if (!started && serial_clock_line) begin
          lead <= lead + 1;
        end
        if (sclkQ && !serial_clock_line) begin
          started <= 1'b1;
          hCnt <= 1;
          if (!started && lead != 20) begin
            timeErr <= timeErr + 1;
          end
          if (nBit == 6'h00) begin
            miso <= txWord[31];
            shTx <= {txWord[30:0], 1'b1};
          end else begin
            miso <= shTx[31];
            shTx <= {shTx[30:0], 1'b1};
          end
        end
        if (!sclkQ && serial_clock_line) begin
          if (hCnt != 10) begin
            timeErr <= timeErr + 1;
          end
          shRx <= {shRx[30:0], mosi};
          nBit <= (nBit == 6'h1f) ? 6'h00 : nBit + 6'h01;
          if (nBit == 6'h1f) begin
            rxWord <= {shRx[30:0], mosi};
            frameDone <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/frs_reload_master_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module frs_reload_master_tb_top;
  localparam logic [31:0] IDLE   = frs_pkg::IDLE_WORD;
  localparam logic [31:0] ERASEW = 32'h3c3c_0302;
  localparam logic [31:0] WADDR  = 32'h0000_4000;
  localparam logic [31:0] WNUM   = 32'h0000_0002;
  localparam logic [31:0] STRAY  = 32'h0000_5678;
  localparam logic [31:0] EXPDEV [9] = '{frs_pkg::CODE_ENABLED,
    frs_pkg::CODE_READY, ERASEW, frs_pkg::CODE_ERASE_OK, WADDR, WNUM,
    frs_pkg::CODE_WR_REQ, frs_pkg::CODE_WR_REQ, frs_pkg::CODE_WR_END};
  // host answers
  localparam logic [31:0] REPLY [9] = '{STRAY, ERASEW, IDLE, WADDR,
    WNUM, IDLE, IDLE, IDLE, IDLE};
  logic        clock;
  logic        arst_n      = 1'b0;
  logic        clkEn       = 1'b1;
  logic [4:0]  address     = 5'h00;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h0000_0000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        serial_clock_line;
  logic        mosi;
  logic        miso;
  logic        slave_select_line;
  logic        flashReq;
  logic        flashErase;
  logic [31:0] flashAddr;
  logic [31:0] flashData;
  logic        flashAck    = 1'b0;
  logic        resumeFromFlash;
  logic [31:0] txWord      = 32'hffff_ffff;
  logic        frameDone;
  logic [31:0] rxWord;
  logic [31:0] rd;
  int          timeErr;
  int          err_total   = 0;
  int          n_checks    = 0;
  int          k           = 0;
  int          polls       = 0;
  int          dIdx        = 0;
  int          dLeft       = 0;
  int          nErase      = 0;
  int          nProg       = 0;
  int          ackWait     = 0;
  int          t;

  frs_reload_master i_frs_reload_master (
    .clock            (clock),
    .arst_n           (arst_n),
    .clkEn            (clkEn),
    .address          (address),
    .read             (read),
    .write            (write),
    .writedata        (writedata),
    .readdata         (readdata),
    .waitrequest      (waitrequest),
    .serial_clock_line(serial_clock_line),
    .mosi             (mosi),
    .miso             (miso),
    .slave_select_line(slave_select_line),
    .flashReq         (flashReq),
    .flashErase       (flashErase),
    .flashAddr        (flashAddr),
    .flashData        (flashData),
    .flashAck         (flashAck),
    .resumeFromFlash  (resumeFromFlash)
  );

  frs_host_model i_frs_host_model (
    .clock            (clock),
    .arst_n           (arst_n),
    .serial_clock_line(serial_clock_line),
    .mosi             (mosi),
    .slave_select_line(slave_select_line),
    .txWord           (txWord),
    .miso             (miso),
    .frameDone        (frameDone),
    .rxWord           (rxWord),
    .timeErr          (timeErr)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [31:0] dword(input int i);
    return 32'h5a00_0000 | 32'(i);
  endfunction

  task automatic cmp32(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // entered just after a rising edge; one idle cycle after each access
  task automatic bus_xfer(input logic wr, input logic [4:0] a,
                          input logic [31:0] wd, output logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) err_total++;
    d = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // word stream from the device and the host's answers
  always @(posedge clock) begin
    if (frameDone === 1'b1 && rxWord !== IDLE) begin
      if (k < 9) cmp32("device word", EXPDEV[k], rxWord);
      else cmp32("extra word", IDLE, rxWord);
      if (k == 1) cmp32("stray start", 32'h1, {31'h0, polls > 3});
      if (k == 6 || k == 7) begin
        txWord <= dword(dIdx);
        dLeft <= 64;
      end else begin
        txWord <= (k < 9) ? REPLY[k] : IDLE;
      end
      k <= k + 1;
    end else if (frameDone === 1'b1 && dLeft > 0) begin
      dIdx <= dIdx + 1;
      dLeft <= dLeft - 1;
      txWord <= (dLeft > 1) ? dword(dIdx + 1) : IDLE;
    end else if (frameDone === 1'b1 && k == 1) begin
      polls <= polls + 1;
      if (polls == 2) txWord <= frs_pkg::CODE_START;
    end
  end

  // flash side: acks after 0..2 cycles
  always @(posedge clock) begin
    if (flashReq === 1'b1 && flashAck === 1'b0 &&
        ackWait >= (nErase + nProg) % 3) begin
      flashAck <= 1'b1;
      ackWait <= 0;
      if (flashErase === 1'b1) begin
        cmp32("erase block", 32'(8'h03 + nErase), {24'h0, flashAddr[7:0]});
        cmp32("erase first", 32'h0, 32'(nProg));
        nErase <= nErase + 1;
      end else begin
        cmp32("program addr", WADDR + frs_pkg::PE_OFFSET + 32'(4 * nProg), flashAddr);
        cmp32("program data", dword(nProg), flashData);
        nProg <= nProg + 1;
      end
    end else if (flashReq === 1'b1 && flashAck === 1'b0) begin
      ackWait <= ackWait + 1;
    end else begin
      flashAck <= 1'b0;
    end
  end

  initial begin
    repeat (300000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    cmp32("reset pins", 32'h38, {26'h0, waitrequest, serial_clock_line, mosi, slave_select_line, flashReq, resumeFromFlash});
    bus_xfer(1'b0, frs_pkg::REG_STAT, 32'h0, rd);
    cmp32("status reset", 32'h0000_01a0, rd);
    bus_xfer(1'b1, 5'h18, 32'h1234_5678, rd);
    bus_xfer(1'b0, 5'h18, 32'h0, rd);
    cmp32("unmapped", 32'h0, rd);
    bus_xfer(1'b1, frs_pkg::REG_CTRL, 32'h1, rd);
    bus_xfer(1'b0, frs_pkg::REG_CTRL, 32'h0, rd);
    cmp32("busy", 32'h1, {31'h0, rd[0]});
    t = 0;
    while (resumeFromFlash !== 1'b1 && t < 150000) begin
      @(posedge clock);
      t++;
    end
    cmp32("resume", 32'h1, {31'h0, resumeFromFlash});
    repeat (800) @(posedge clock);
    bus_xfer(1'b0, frs_pkg::REG_ERASE, 32'h0, rd);
    cmp32("erase word", ERASEW, rd);
    bus_xfer(1'b0, frs_pkg::REG_WADDR, 32'h0, rd);
    cmp32("write address", WADDR, rd);
    bus_xfer(1'b0, frs_pkg::REG_WNUM, 32'h0, rd);
    cmp32("write count", WNUM, rd);
    bus_xfer(1'b0, frs_pkg::REG_DLCNT, 32'h0, rd);
    cmp32("pages loaded", 32'h2, rd);
    bus_xfer(1'b0, frs_pkg::REG_STAT, 32'h0, rd);
    cmp32("status done", 32'h0000_00a8, rd & 32'h0000_00f8);
    cmp32("word count", 32'h9, 32'(k));
    cmp32("erase count", 32'h2, 32'(nErase));
    cmp32("program count", 32'h80, 32'(nProg));
    cmp32("link timing", 32'h0, 32'(timeErr));
    tally_and_finish();
  end
endmodule
`default_nettype wire
